// File: csp_pkg.sv
// constants shared by both ends of the serial configuration port
// assumes: 8-bit instruction, one or two data bytes, 6-bit register address
package csp_pkg;

  // frame layout, counted in rising serial clock edges
  localparam logic [4:0] INSTR_DONE = 5'h08;
  localparam logic [4:0] END_ONE_BYTE = 5'h10;
  localparam logic [4:0] END_TWO_BYTE = 5'h18;

  // instruction byte fields
  localparam int RW_BIT = 7;
  localparam int LEN_BIT = 6;
  localparam int ADDR_W = 6;

  // serial clock made by the controller from aclk
  localparam int ACLK_PERIOD_NS = 50;
  localparam int SCLK_MAX_RATE_MHZ = 30;
  localparam int SCLK_MIN_PERIOD_NS = (1000 + SCLK_MAX_RATE_MHZ - 1) / SCLK_MAX_RATE_MHZ;
  localparam int SCLK_MIN_HALF_CYC =
    (SCLK_MIN_PERIOD_NS + 2 * ACLK_PERIOD_NS - 1) / (2 * ACLK_PERIOD_NS);
  localparam logic [2:0] SCLK_HALF_CYCLES = 3'h4;
  localparam logic [2:0] SCLK_LAST_PH = 3'(2 * int'(SCLK_HALF_CYCLES) - 1);

  // controller register map (axi4-lite, byte addresses)
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] OFF_CMD = 4'h0;
  localparam logic [3:0] OFF_CFG = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_RDATA = 4'hc;
  localparam int CMD_D1_LSB = 8;
  localparam int CMD_D2_LSB = 16;
  localparam int CMD_D1_HI = CMD_D1_LSB + 7;
  localparam int CMD_D2_HI = CMD_D2_LSB + 7;
  localparam int CFG_LSB_FIRST_BIT = 0;
  localparam int CFG_THREE_WIRE_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: csp_link_if.sv
// serial link between controller and configuration port
// assumes: the bench joins both ends here; undriven data lines read high
`timescale 1ns/1ps
`default_nettype none

interface csp_link_if;
  logic serial_port_enable_n;
  logic sclk;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic serial_data_out_dedicated;
  logic sdo_oe;
  logic sdio_level;
  logic sdo_level;

  // wire levels worked out from the enables, weak pull-up when idle
  assign sdio_level = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
  assign sdo_level = sdo_oe ? serial_data_out_dedicated : 1'b1;

  modport host (
    output serial_port_enable_n,
    output sclk,
    output host_sdio_o,
    output host_sdio_oe,
    input sdio_level,
    input sdo_level
  );

  modport device (
    input serial_port_enable_n,
    input sclk,
    input sdio_level,
    output dev_sdio_o,
    output dev_sdio_oe,
    output serial_data_out_dedicated,
    output sdo_oe
  );
endinterface // csp_link_if

`default_nettype wire

// File: csp_device.sv
// configuration port end: serial slave that reads and writes a register bank
// assumes: bank lives in the serial clock domain, reads are combinational,
// and a write lands at the rising edge where reg_wr_en is high
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - enable high floats both data outputs
// - sample rising edge, drive falling edge
// - write commits at edge 16 or 24
// - short frame discards the partial write
// - sdio is input except during a three-wire read
// - three-wire mode keeps dedicated output floating
// - eight instruction edges, then data phase
// - instruction bit 7 selects read
// - instruction bit 6 selects two bytes
// - instruction bits 5..0 give start address
// - second byte address down msb, up lsb
// - lsb-first reverses instruction and data bytes
// - writes always enter on sdio
// - read shifts eight bits per byte out
// - three-wire read turns sdio to output
// - controller keeps serial rate within 30 MHz
module csp_device (
  // serial link, clocked by its own serial clock
  csp_link_if.device link,
  // configuration bits driven as straps, not from the register bank
  input wire logic lsb_first,
  input wire logic three_wire_select,
  // register bank write port
  output logic reg_wr_en,
  output logic [csp_pkg::ADDR_W-1:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  // register bank read port
  output logic [csp_pkg::ADDR_W-1:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  // frame status
  output logic frame_active
);

  logic frame_reset;
  logic sdi;
  logic [4:0] edge_count;
  logic [4:0] next_edge_count;
  logic [7:0] instr;
  logic [7:0] next_instr;
  logic [7:0] data_sr;
  logic [7:0] next_data;
  logic in_instr;
  logic instr_ready;
  logic read_not_write_flag;
  logic two_byte_flag;
  logic [csp_pkg::ADDR_W-1:0] start_addr;
  logic [csp_pkg::ADDR_W-1:0] second_addr;
  logic [4:0] frame_end;
  logic in_data_phase;
  logic second_byte;
  logic [2:0] bit_pos;
  logic [2:0] bit_sel;
  logic read_phase;
  logic out_bit;
  logic out_drive;
  logic sdio_drive;

  assign frame_reset = link.serial_port_enable_n;
  // all input bits, write data included, arrive on sdio
  assign sdi = link.sdio_level;

  // --- bit counting and instruction capture --------------------------

  assign in_instr = edge_count < csp_pkg::INSTR_DONE;
  assign instr_ready = !in_instr;

  // saturate so stray edges after the frame end do nothing
  assign next_edge_count = (edge_count == csp_pkg::END_TWO_BYTE) ?
    edge_count : edge_count + 5'h01;

  // one bit enters on each rising edge, order per the configured direction
  assign next_instr = lsb_first ? {sdi, instr[7:1]} : {instr[6:0], sdi};
  assign next_data = lsb_first ? {sdi, data_sr[7:1]} : {data_sr[6:0], sdi};

  // enable high acts as the frame reset of every link flop
  always_ff @(posedge link.sclk or posedge frame_reset) begin
    if (frame_reset) begin
      edge_count <= 5'h00;
      instr <= 8'h00;
      data_sr <= 8'h00;
    end else begin
      edge_count <= next_edge_count;
      if (in_instr) begin
        instr <= next_instr;
      end else begin
        data_sr <= next_data;
      end
    end
  end

  // --- instruction decode ---------------------------------------------

  assign read_not_write_flag = instr_ready && instr[csp_pkg::RW_BIT];
  assign two_byte_flag = instr[csp_pkg::LEN_BIT];
  assign start_addr = instr[csp_pkg::ADDR_W-1:0];

  // second byte walks down in msb-first order, up in lsb-first order
  assign second_addr = lsb_first ? start_addr + 6'h01 : start_addr - 6'h01;

  assign frame_end = two_byte_flag ? csp_pkg::END_TWO_BYTE : csp_pkg::END_ONE_BYTE;
  assign in_data_phase = instr_ready && (edge_count < frame_end);
  assign second_byte = edge_count >= csp_pkg::END_ONE_BYTE;

  // --- write commit ------------------------------------------------------

  // the commit happens at the 16th or 24th rising edge itself; an enable
  // that rises earlier clears the counter, so no commit is ever seen
  assign reg_wr_en = instr_ready && !instr[csp_pkg::RW_BIT] &&
    ((edge_count == csp_pkg::END_ONE_BYTE - 5'h01) ||
     (two_byte_flag && edge_count == csp_pkg::END_TWO_BYTE - 5'h01));
  assign reg_wr_addr = second_byte ? second_addr : start_addr;
  assign reg_wr_data = next_data;

  // --- readback ----------------------------------------------------------

  assign reg_rd_addr = second_byte ? second_addr : start_addr;

  // position within the current data byte, then bit index by order
  assign bit_pos = edge_count[2:0];
  assign bit_sel = lsb_first ? bit_pos : 3'h7 - bit_pos;
  assign read_phase = read_not_write_flag && in_data_phase;

  // output changes only on the falling edge, so it is stable at the rise
  always_ff @(negedge link.sclk or posedge frame_reset) begin
    if (frame_reset) begin
      out_bit <= 1'b0;
      out_drive <= 1'b0;
    end else begin
      out_bit <= reg_rd_data[bit_sel];
      out_drive <= read_phase;
    end
  end

  // --- pin steering ----------------------------------------------------

  // sdio is an input except during a three-wire read
  assign sdio_drive = out_drive && three_wire_select;

  assign link.dev_sdio_o = out_bit;
  assign link.dev_sdio_oe = sdio_drive && !frame_reset;
  assign link.serial_data_out_dedicated = out_bit;
  // dedicated output floats in three-wire mode and between frames
  assign link.sdo_oe = out_drive && !three_wire_select && !frame_reset;

  assign frame_active = !frame_reset;

endmodule // csp_device

`default_nettype wire

// File: csp_host.sv
// controller end: axi4-lite slave that runs one serial frame per command
// assumes: aclk at 20 MHz; the serial clock is divided from it and driven out
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module csp_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [csp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [csp_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial link
  csp_link_if.host link
);

  typedef enum logic [1:0] {CSP_IDLE, CSP_SHIFT, CSP_TAIL} csp_state_type;

  function automatic logic [7:0] csp_order(input logic [7:0] b, input logic lsb);
    logic [7:0] r;
    r = b;
    if (lsb) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7 - i];
      end
    end
    return r;
  endfunction

  csp_state_type state;
  logic aw_got;
  logic w_got;
  logic [csp_pkg::AXI_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [1:0] cfg;
  logic [23:0] tx_sr;
  logic [23:0] rx_sr;
  logic [7:0] instr;
  logic [2:0] ph;
  logic [4:0] bit_idx;
  logic miso_meta;
  logic miso_sync;
  logic frame_enable_n;
  logic sclk;
  logic mosi_oe;
  logic do_write;
  logic cmd_hit;
  logic start;
  logic is_read;
  logic [4:0] total;
  logic ph_last;
  logic bit_last;
  logic [2:0] next_ph;
  logic [7:0] rd_b1;
  logic [7:0] rd_b2;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;

  // --- axi4-lite slave -------------------------------------------------

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign wr_hit = aw_addr == csp_pkg::OFF_CMD || aw_addr == csp_pkg::OFF_CFG;
  assign cmd_hit = do_write && aw_addr == csp_pkg::OFF_CMD && (&s_axi_wstrb[2:0]);
  assign start = cmd_hit && state == CSP_IDLE;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit = s_axi_araddr == csp_pkg::OFF_CMD || s_axi_araddr == csp_pkg::OFF_CFG ||
    s_axi_araddr == csp_pkg::OFF_STATUS || s_axi_araddr == csp_pkg::OFF_RDATA;

  // single-byte data lands in the low bits of the capture register
  assign rd_b1 = csp_order(instr[csp_pkg::LEN_BIT] ? rx_sr[15:8] : rx_sr[7:0],
    cfg[csp_pkg::CFG_LSB_FIRST_BIT]);
  assign rd_b2 = csp_order(rx_sr[7:0], cfg[csp_pkg::CFG_LSB_FIRST_BIT]);
  assign rd_mux =
    (s_axi_araddr == csp_pkg::OFF_CMD) ? {24'h000000, instr} :
    (s_axi_araddr == csp_pkg::OFF_CFG) ? {30'h00000000, cfg} :
    (s_axi_araddr == csp_pkg::OFF_STATUS) ? {31'h00000000, state != CSP_IDLE} :
    (s_axi_araddr == csp_pkg::OFF_RDATA) ? {16'h0000, rd_b2, rd_b1} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= csp_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= csp_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      cfg <= csp_pkg::CFG_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
        if (aw_addr == csp_pkg::OFF_CFG && s_axi_wstrb[0]) begin
          cfg <= w_data[1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --- serial engine ---------------------------------------------------

  assign is_read = instr[csp_pkg::RW_BIT];
  assign total = instr[csp_pkg::LEN_BIT] ? csp_pkg::END_TWO_BYTE : csp_pkg::END_ONE_BYTE;
  assign ph_last = ph == csp_pkg::SCLK_LAST_PH;
  assign bit_last = bit_idx == total - 5'h01;
  assign next_ph = ph + 3'h1;

  // readback pin passes two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      miso_meta <= 1'b1;
      miso_sync <= 1'b1;
    end else begin
      miso_meta <= cfg[csp_pkg::CFG_THREE_WIRE_BIT] ? link.sdio_level : link.sdo_level;
      miso_sync <= miso_meta;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CSP_IDLE;
      frame_enable_n <= 1'b1;
      sclk <= 1'b0;
      ph <= 3'h0;
      bit_idx <= 5'h00;
      tx_sr <= 24'h000000;
      rx_sr <= 24'h000000;
      instr <= 8'h00;
      mosi_oe <= 1'b0;
    end else begin
      case (state)
        CSP_IDLE: begin
          frame_enable_n <= 1'b1;
          sclk <= 1'b0;
          mosi_oe <= 1'b0;
          ph <= 3'h0;
          bit_idx <= 5'h00;
          if (start) begin
            instr <= w_data[7:0];
            // every byte, instruction first, goes out in the chosen order
            tx_sr <= {csp_order(w_data[7:0], cfg[csp_pkg::CFG_LSB_FIRST_BIT]),
              csp_order(w_data[csp_pkg::CMD_D1_HI:csp_pkg::CMD_D1_LSB],
                cfg[csp_pkg::CFG_LSB_FIRST_BIT]),
              csp_order(w_data[csp_pkg::CMD_D2_HI:csp_pkg::CMD_D2_LSB],
                cfg[csp_pkg::CFG_LSB_FIRST_BIT])
            };
            frame_enable_n <= 1'b0;
            mosi_oe <= 1'b1;
            state <= CSP_SHIFT;
          end
        end
        CSP_SHIFT: begin
          ph <= ph_last ? 3'h0 : next_ph;
          // low half then high half: rises mid-bit, falls as the bit ends
          sclk <= !ph_last && next_ph >= csp_pkg::SCLK_HALF_CYCLES;
          if (ph == csp_pkg::SCLK_HALF_CYCLES) begin
            rx_sr <= {rx_sr[22:0], miso_sync};
          end
          if (ph_last) begin
            tx_sr <= {tx_sr[22:0], 1'b0};
            bit_idx <= bit_idx + 5'h01;
            // release sdio before the device turns it round
            if (is_read && cfg[csp_pkg::CFG_THREE_WIRE_BIT] &&
                bit_idx == csp_pkg::INSTR_DONE - 5'h01) begin
              mosi_oe <= 1'b0;
            end
            if (bit_last) begin
              state <= CSP_TAIL;
              ph <= 3'h0;
            end
          end
        end
        CSP_TAIL: begin
          ph <= next_ph;
          if (ph == csp_pkg::SCLK_HALF_CYCLES) begin
            frame_enable_n <= 1'b1;
            mosi_oe <= 1'b0;
            state <= CSP_IDLE;
          end
        end
        default: begin
          state <= CSP_IDLE;
        end
      endcase
    end
  end

  assign link.serial_port_enable_n = frame_enable_n;
  assign link.sclk = sclk;
  assign link.host_sdio_o = tx_sr[23];
  assign link.host_sdio_oe = mosi_oe;

endmodule // csp_host

`default_nettype wire

// File: csp_properties.sv
// link checker: timing of the serial frame as seen from the host clock
// assumes: sclk is divided from aclk, so every link change lands on an aclk edge
`timescale 1ns/1ps
`default_nettype none

module csp_properties (
  // host clock domain
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  input wire logic serial_port_enable_n,
  input wire logic sclk,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe,
  input wire logic serial_data_out_dedicated,
  input wire logic sdo_oe,
  input wire logic sdio_level,
  input wire logic sdo_level
);
  logic sclk_d;
  logic [4:0] edge_cnt;
  wire sclk_rise = sclk && !sclk_d;

  // rising serial edges seen in the current frame
  always_ff @(posedge aclk) begin
    sclk_d <= aresetn && sclk;
    if (!aresetn || serial_port_enable_n) edge_cnt <= 5'h00;
    else if (sclk_rise) edge_cnt <= edge_cnt + 5'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_frame_open;
    $fell(serial_port_enable_n) ##1 !serial_port_enable_n [*8];
  endsequence
  property p_frame_len;
    s_frame_open |-> ##[100:230] serial_port_enable_n;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length out of range");
  property p_edge_total;
    $rose(serial_port_enable_n) |->
      (edge_cnt == csp_pkg::END_ONE_BYTE) || (edge_cnt == csp_pkg::END_TWO_BYTE);
  endproperty
  a_edge_total: assert property (p_edge_total)
    else $error("frame did not end after 16 or 24 edges");
  property p_idle_float;
    serial_port_enable_n |-> !dev_sdio_oe && !sdo_oe && !sclk;
  endproperty
  a_idle_float: assert property (p_idle_float)
    else $error("device drives while enable is high");
  property p_one_driver;
    !(dev_sdio_oe && sdo_oe) && !(dev_sdio_oe && host_sdio_oe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("two drivers on the data lines");
  property p_sdio_turn;
    $rose(dev_sdio_oe) |-> edge_cnt == csp_pkg::INSTR_DONE;
  endproperty
  a_sdio_turn: assert property (p_sdio_turn)
    else $error("sdio turned round away from edge 8");
  property p_sdo_start;
    $rose(sdo_oe) |-> edge_cnt == csp_pkg::INSTR_DONE;
  endproperty
  a_sdo_start: assert property (p_sdo_start)
    else $error("dedicated output started away from edge 8");
  property p_sdo_fall;
    sdo_oe && $past(sdo_oe) && $changed(serial_data_out_dedicated) |-> $fell(sclk);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall)
    else $error("dedicated output moved off the falling edge");
  property p_sdio_fall;
    dev_sdio_oe && $past(dev_sdio_oe) && $changed(dev_sdio_o) |-> $fell(sclk);
  endproperty
  a_sdio_fall: assert property (p_sdio_fall)
    else $error("sdio readback moved off the falling edge");
  property p_host_setup;
    $rose(sclk) && host_sdio_oe |-> $stable(host_sdio_o);
  endproperty
  a_host_setup: assert property (p_host_setup)
    else $error("host data changed at the rising edge");
endmodule // csp_properties

`default_nettype wire

// File: testbench.sv
// bench: host and device joined by the link, register bank on the device side
// assumes: straps of the device are set to match the host configuration
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct packed {
    logic [1:0] cfg;
    logic two;
    logic [5:0] addr;
    logic [7:0] d1;
    logic [7:0] d2;
  } csp_row_type;
  localparam int CEIL = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] aw_a = 4'h0;
  logic [3:0] ar_a = 4'h0;
  logic [31:0] wd = 32'h0;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_d;
  logic lsb = 1'b0, tw = 1'b0;
  logic wr_en;
  logic fa;
  logic [5:0] wr_a, rd_a;
  logic [7:0] wr_d;
  logic [7:0] bank [64];
  logic [23:0] cap_io = 24'h0, cap_do = 24'h0;
  int err_count = 0, n_checks = 0, cyc = 0;
  csp_row_type rows [5] = '{
    '{2'h0, 1'b1, 6'h10, 8'ha5, 8'h3c}, '{2'h1, 1'b1, 6'h3f, 8'h81, 8'h7e},
    '{2'h2, 1'b1, 6'h00, 8'hc3, 8'h18}, '{2'h3, 1'b0, 6'h21, 8'h96, 8'h00},
    '{2'h0, 1'b0, 6'h05, 8'h01, 8'h00}};

  always #25 aclk = !aclk;

  csp_link_if link ();
  csp_properties i_csp_properties (.aclk(aclk), .aresetn(aresetn),
    .serial_port_enable_n(link.serial_port_enable_n), .sclk(link.sclk),
    .host_sdio_o(link.host_sdio_o), .host_sdio_oe(link.host_sdio_oe),
    .dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe(link.dev_sdio_oe),
    .serial_data_out_dedicated(link.serial_data_out_dedicated), .sdo_oe(link.sdo_oe),
    .sdio_level(link.sdio_level), .sdo_level(link.sdo_level));
  csp_host i_csp_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .link(link));
  csp_device i_csp_device (.link(link), .lsb_first(lsb), .three_wire_select(tw),
    .reg_wr_en(wr_en), .reg_wr_addr(wr_a), .reg_wr_data(wr_d), .reg_rd_addr(rd_a),
    .reg_rd_data(bank[rd_a]), .frame_active(fa));

  // bank and wire capture live on the serial clock
  initial for (int i = 0; i < 64; i++) bank[i] = 8'(i * 7);
  always @(posedge link.sclk) begin
    if (wr_en) bank[wr_a] <= wr_d;
    cap_io <= {cap_io[22:0], link.sdio_level};
    cap_do <= {cap_do[22:0], link.sdo_level};
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      err_count++;
      print_verdict();
    end
  end

  function automatic logic [7:0] wire8(input logic [7:0] v, input logic rev);
    logic [7:0] o;
    for (int i = 0; i < 8; i++) o[i] = rev ? v[7-i] : v[i];
    return o;
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected resp at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    aw_a <= a;
    wd <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge aclk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
    end while ((aw_v && !aw_rdy) || (w_v && !w_rdy));
    do @(posedge aclk); while (b_v !== 1'b1);
    rsp = b_resp;
    b_r <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do @(posedge aclk); while (ar_rdy !== 1'b1);
    ar_v <= 1'b0;
    do @(posedge aclk); while (r_v !== 1'b1);
    d = r_d;
    rsp = r_resp;
    r_r <= 1'b0;
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] rsp;
    do axi_rd(csp_pkg::OFF_STATUS, d, rsp); while (d[0] !== 1'b0);
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    lsb <= 1'b0;
    tw <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic run_row(input csp_row_type r);
    logic [5:0] a2;
    logic [7:0] keep, i1;
    logic [15:0] msk;
    logic [23:0] rc;
    logic [31:0] d;
    logic [1:0] rsp;
    a2 = r.cfg[0] ? r.addr + 6'h01 : r.addr - 6'h01;
    keep = bank[a2];
    msk = r.two ? 16'hffff : 16'h00ff;
    i1 = {1'b0, r.two, r.addr};
    axi_wr(csp_pkg::OFF_CFG, {30'h0, r.cfg}, rsp);
    chk_resp(rsp, csp_pkg::RESP_OKAY);
    lsb <= r.cfg[0];
    tw <= r.cfg[1];
    axi_wr(csp_pkg::OFF_CMD, {8'h00, r.d2, r.d1, i1}, rsp);
    wait_idle();
    chk_word(bank[r.addr], r.d1);
    chk_word(bank[a2], r.two ? r.d2 : keep);
    if (r.two) chk_word(cap_io, {wire8(i1, r.cfg[0]), wire8(r.d1, r.cfg[0]),
      wire8(r.d2, r.cfg[0])});
    axi_wr(csp_pkg::OFF_CMD, {16'h0000, 1'b1, r.two, r.addr}, rsp);
    wait_idle();
    rc = r.cfg[1] ? cap_io : cap_do;
    chk_word(r.two ? rc[15:0] : {8'h00, rc[7:0]}, r.two ? {wire8(r.d1, r.cfg[0]),
      wire8(r.d2, r.cfg[0])} : {8'h00, wire8(r.d1, r.cfg[0])});
    axi_rd(csp_pkg::OFF_RDATA, d, rsp);
    chk_word(d[15:0] & msk, {r.d2, r.d1} & msk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin : main
    logic [31:0] d;
    logic [1:0] rsp;
    logic [7:0] keep;
    do_reset();
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("test row %0d done", i);
    end
    // second reset in mid-run returns the configuration to its default
    axi_wr(csp_pkg::OFF_CFG, 32'h00000003, rsp);
    do_reset();
    axi_rd(csp_pkg::OFF_CFG, d, rsp);
    chk_word(d[1:0], csp_pkg::CFG_RESET);
    chk_resp(rsp, csp_pkg::RESP_OKAY);
    axi_rd(csp_pkg::OFF_STATUS, d, rsp);
    chk_word(d[0], 32'h0);
    // write to the status register and misaligned read answer with an error
    axi_wr(csp_pkg::OFF_STATUS, 32'h00000001, rsp);
    chk_resp(rsp, csp_pkg::RESP_SLVERR);
    axi_rd(4'h2, d, rsp);
    chk_resp(rsp, csp_pkg::RESP_SLVERR);
    $display("test reset done");
    // a command offered while a frame runs is dropped with an okay answer
    keep = bank[6'h2b];
    axi_wr(csp_pkg::OFF_CMD, {16'h005a, 8'h2a}, rsp);
    chk_word(fa, 32'h1);
    axi_wr(csp_pkg::OFF_CMD, {16'h0077, 8'h2b}, rsp);
    chk_resp(rsp, csp_pkg::RESP_OKAY);
    wait_idle();
    chk_word(fa, 32'h0);
    chk_word(bank[6'h2a], 32'h5a);
    chk_word(bank[6'h2b], keep);
    $display("test busy command done");
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
